// file: core/rtc_map.vh
/*
 * Shared constants of the BCD calendar clock core: register
 * addresses, field positions, reset values, BCD limits and the
 * oscillator divider figures.
 * Assumes it is included by bare name from the core/ modules.
 */
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

////////////////////////////////////////////////////////////////////
// Register addresses (3-bit pointer)
`define REG_SECONDS 3'h0
`define REG_MINUTES 3'h1
`define REG_HOURS 3'h2
`define REG_WEEKDAY 3'h3
`define REG_DATE 3'h4
`define REG_MONTH 3'h5
`define REG_YEAR 3'h6
`define REG_CONTROL 3'h7
`define PTR_STEP 3'h1

////////////////////////////////////////////////////////////////////
// Field positions and reset values
`define SEC_HALT_BIT 7
`define HR_CEN_BIT 7
`define HR_CFLAG_BIT 6
`define CTL_OUT_BIT 7
`define CTL_FT_BIT 6
`define CTL_SIGN_BIT 5
`define CTL_RESET 8'h80

////////////////////////////////////////////////////////////////////
// BCD limits of the calendar fields
`define SEC_LAST 7'h59
`define MIN_LAST 7'h59
`define HR_LAST 6'h23
`define DOW_FIRST 3'h1
`define DOW_LAST 3'h7
`define DATE_FIRST 6'h01
`define MON_FIRST 5'h01
`define MON_LAST 5'h12
`define YR_LAST 8'h99
`define MON_FEB 5'h02
`define MON_APR 5'h04
`define MON_JUN 5'h06
`define MON_SEP 5'h09
`define MON_NOV 5'h11
`define DAYS_28 6'h28
`define DAYS_29 6'h29
`define DAYS_30 6'h30
`define DAYS_31 6'h31

////////////////////////////////////////////////////////////////////
// Oscillator divider and timing
`define OSC_SEC_CYCLES 16'h8000
`define CAL_SHORTEN 16'h0080
`define CAL_LENGTHEN 16'h0100
`define SEC_IN_MIN_LAST 6'h3b
`define TEST_HALF_LAST 5'h1f
`define CLK_HZ 20000000
`define HOLD_MS 250
`define MS_PER_S 1000

`endif

// file: core/osc_divider.v
/*
 * Oscillator divider: synchronises the crystal pin, divides it to a
 * one-second tick with periodic calibration, and makes the raw
 * 512 Hz test wave.
 * Assumes halt and calibration inputs come from sys_clk logic.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rtc_map.vh"

module osc_divider (
    input wire sys_clk,
    input wire reset_n,
    input wire osc_clk_pin,
    input wire halt,
    input wire [4:0] cal_mag,
    input wire cal_positive,
    output reg sec_tick,
    output reg test_wave
);

reg osc_s1_r, osc_s2_r, osc_s3_r;
reg [4:0] raw_cnt_r;
reg [15:0] div_cnt_r;
reg [5:0] sec_in_min_r;
reg [5:0] cyc_min_r;
wire osc_edge;
wire run;
wire corr;
wire [15:0] div_last;

////////////////////////////////////////////////////////////////////
// Pin synchroniser, then rising edge on the second stage only
always @(posedge sys_clk) begin
    osc_s1_r <= osc_clk_pin;
    osc_s2_r <= osc_s1_r;
    osc_s3_r <= osc_s2_r;
end

assign osc_edge = osc_s2_r & ~osc_s3_r;
assign run = osc_edge & ~halt;

// Correct the first second of each early minute in the cycle
assign corr = (sec_in_min_r == 6'h00) &&
              (cyc_min_r < {cal_mag, 1'b0});
assign div_last = !corr ? (`OSC_SEC_CYCLES - 16'h0001) :
                  cal_positive ?
                  (`OSC_SEC_CYCLES - `CAL_SHORTEN - 16'h0001) :
                  (`OSC_SEC_CYCLES + `CAL_LENGTHEN - 16'h0001);

////////////////////////////////////////////////////////////////////
// Raw prescaler: separate from the corrected chain so trim never
// shows on the test wave
always @(posedge sys_clk) begin
    if (!reset_n) begin
        raw_cnt_r <= 5'h00;
        test_wave <= 1'b1;
    end else if (run) begin
        raw_cnt_r <= raw_cnt_r + 5'h01;
        if (raw_cnt_r == `TEST_HALF_LAST) begin
            test_wave <= ~test_wave;
        end
    end
end

////////////////////////////////////////////////////////////////////
// Corrected divider, seconds-in-minute and 64-minute cycle
always @(posedge sys_clk) begin
    if (!reset_n) begin
        div_cnt_r <= 16'h0000;
        sec_in_min_r <= 6'h00;
        cyc_min_r <= 6'h00;
        sec_tick <= 1'b0;
    end else begin
        sec_tick <= 1'b0;
        if (run) begin
            if (div_cnt_r >= div_last) begin
                div_cnt_r <= 16'h0000;
                sec_tick <= 1'b1;
                if (sec_in_min_r >= `SEC_IN_MIN_LAST) begin
                    sec_in_min_r <= 6'h00;
                    cyc_min_r <= cyc_min_r + 6'h01;
                end else begin
                    sec_in_min_r <= sec_in_min_r + 6'h01;
                end
            end else begin
                div_cnt_r <= div_cnt_r + 16'h0001;
            end
        end
    end
end

endmodule // osc_divider
`default_nettype wire

// file: core/calendar_step.v
/*
 * Calendar step: combinational next value of every time field for
 * one elapsed second, with BCD carries, month length, leap years
 * and the century flag.
 * Assumes fields hold BCD; out-of-range values roll to the minimum.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rtc_map.vh"

module calendar_step (
    input wire [6:0] sec,
    input wire [6:0] min,
    input wire [5:0] hr,
    input wire cen,
    input wire cflag,
    input wire [2:0] dow,
    input wire [5:0] date,
    input wire [4:0] mon,
    input wire [7:0] yr,
    output wire [6:0] sec_nxt,
    output wire [6:0] min_nxt,
    output wire [5:0] hr_nxt,
    output wire cflag_nxt,
    output wire [2:0] dow_nxt,
    output wire [5:0] date_nxt,
    output wire [4:0] mon_nxt,
    output wire [7:0] yr_nxt
);

// Add one to a two-digit BCD value
function [7:0] bcd_inc;
    input [7:0] v;
    begin
        if (v[3:0] >= 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    end
endfunction

// Years divisible by four: even tens with 0/4/8, odd tens with 2/6
function is_leap;
    input [7:0] y;
    begin
        if (y[4]) begin
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end else begin
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                      (y[3:0] == 4'h8);
        end
    end
endfunction

wire [7:0] sec_inc = bcd_inc({1'b0, sec});
wire [7:0] min_inc = bcd_inc({1'b0, min});
wire [7:0] hr_inc = bcd_inc({2'b00, hr});
wire [7:0] date_inc = bcd_inc({2'b00, date});
wire [7:0] mon_inc = bcd_inc({3'b000, mon});
wire [7:0] yr_inc = bcd_inc(yr);
wire [5:0] dim;
wire c_sec, c_min, c_hr, c_date, c_mon, c_yr;

// Month length for the current month and year
assign dim = (mon == `MON_FEB) ?
             (is_leap(yr) ? `DAYS_29 : `DAYS_28) :
             ((mon == `MON_APR) || (mon == `MON_JUN) ||
              (mon == `MON_SEP) || (mon == `MON_NOV)) ?
             `DAYS_30 : `DAYS_31;

// Carry chain from seconds to years
assign c_sec = (sec >= `SEC_LAST);
assign c_min = c_sec && (min >= `MIN_LAST);
assign c_hr = c_min && (hr >= `HR_LAST);
assign c_date = c_hr && (date >= dim);
assign c_mon = c_date && (mon >= `MON_LAST);
assign c_yr = c_mon && (yr >= `YR_LAST);

assign sec_nxt = c_sec ? 7'h00 : sec_inc[6:0];
assign min_nxt = !c_sec ? min : c_min ? 7'h00 : min_inc[6:0];
assign hr_nxt = !c_min ? hr : c_hr ? 6'h00 : hr_inc[5:0];
assign dow_nxt = !c_hr ? dow :
                 (dow >= `DOW_LAST) ? `DOW_FIRST : dow + 3'h1;
assign date_nxt = !c_hr ? date : c_date ? `DATE_FIRST : date_inc[5:0];
assign mon_nxt = !c_date ? mon : c_mon ? `MON_FIRST : mon_inc[4:0];
assign yr_nxt = !c_mon ? yr : c_yr ? 8'h00 : yr_inc;
assign cflag_nxt = cflag ^ (c_yr & cen);

endmodule // calendar_step
`default_nettype wire

// file: core/bcd_calendar_clock_core.v
/*
 * Timekeeping core: eight-byte register file behind the serial
 * slave's address pointer, true time counters, a frozen visible
 * copy for reads, and the open-drain test/level pin driver.
 * Assumes the serial slave (same clock) gives pointer load, byte
 * write, byte read and acknowledge strobes, and a bus_active level
 * from start to stop; the crystal arrives raw on osc_clk_pin.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rtc_map.vh"

module bcd_calendar_clock_core #(
    parameter HOLD_CYCLES = `CLK_HZ / `MS_PER_S * `HOLD_MS,
    parameter HOLD_W = 23
) (
    input wire sys_clk,
    input wire reset_n,
    input wire osc_clk_pin,
    input wire bus_active,
    input wire ptr_load,
    input wire [2:0] ptr_value,
    input wire wr_stb,
    input wire [7:0] wr_data,
    input wire rd_stb,
    input wire ack_stb,
    output reg [7:0] rd_data_r,
    output reg [2:0] reg_ptr_r,
    output reg test_or_level_pin_out_r,
    output reg test_or_level_pin_oe_r
);

// Last count of the freeze window, cut to the counter width on purpose
localparam integer HOLD_LAST_I = HOLD_CYCLES - 1;
localparam [HOLD_W-1:0] HOLD_LAST = HOLD_LAST_I[HOLD_W-1:0];

////////////////////////////////////////////////////////////////////
// Declarations

// True time, counting unless halted
reg [6:0] t_sec_r;
reg [6:0] t_min_r;
reg [5:0] t_hr_r;
reg t_cen_r;
reg t_cflag_r;
reg [2:0] t_dow_r;
reg [5:0] t_date_r;
reg [4:0] t_mon_r;
reg [7:0] t_yr_r;

// Visible copy that reads return
reg [6:0] v_sec_r;
reg [6:0] v_min_r;
reg [5:0] v_hr_r;
reg v_cen_r;
reg v_cflag_r;
reg [2:0] v_dow_r;
reg [5:0] v_date_r;
reg [4:0] v_mon_r;
reg [7:0] v_yr_r;

// Control state
reg halt_r;
reg [7:0] ctrl_r;
reg hold_r;
reg [HOLD_W-1:0] hold_cnt_r;

wire sec_tick;
wire test_wave;
wire [6:0] s_sec;
wire [6:0] s_min;
wire [5:0] s_hr;
wire s_cflag;
wire [2:0] s_dow;
wire [5:0] s_date;
wire [4:0] s_mon;
wire [7:0] s_yr;
wire hold_start;
wire copy_ok;
wire oe_nxt;

////////////////////////////////////////////////////////////////////
// Decoding helpers

// Addresses 0..6 hold the time; 7 is the control byte
function is_clock_addr;
    input [2:0] a;
    begin
        is_clock_addr = (a != `REG_CONTROL);
    end
endfunction

// Write strobe aimed at one address
function wr_hit;
    input stb;
    input [2:0] ptr;
    input [2:0] a;
    begin
        wr_hit = stb && (ptr == a);
    end
endfunction

////////////////////////////////////////////////////////////////////
// Divider and calendar arithmetic

osc_divider u_div (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .osc_clk_pin(osc_clk_pin),
    .halt(halt_r),
    .cal_mag(ctrl_r[4:0]),
    .cal_positive(ctrl_r[`CTL_SIGN_BIT]),
    .sec_tick(sec_tick),
    .test_wave(test_wave)
);

calendar_step u_step (
    .sec(t_sec_r),
    .min(t_min_r),
    .hr(t_hr_r),
    .cen(t_cen_r),
    .cflag(t_cflag_r),
    .dow(t_dow_r),
    .date(t_date_r),
    .mon(t_mon_r),
    .yr(t_yr_r),
    .sec_nxt(s_sec),
    .min_nxt(s_min),
    .hr_nxt(s_hr),
    .cflag_nxt(s_cflag),
    .dow_nxt(s_dow),
    .date_nxt(s_date),
    .mon_nxt(s_mon),
    .yr_nxt(s_yr)
);

////////////////////////////////////////////////////////////////////
// Address pointer: load wins over acknowledge

always @(posedge sys_clk) begin
    if (!reset_n) begin
        reg_ptr_r <= `REG_SECONDS;
    end else if (ptr_load) begin
        reg_ptr_r <= ptr_value;
    end else if (ack_stb) begin
        reg_ptr_r <= reg_ptr_r + `PTR_STEP;
    end
end

////////////////////////////////////////////////////////////////////
// True time: a tick steps every field, a write then overrides the
// addressed field, so a write never costs the other fields a second

always @(posedge sys_clk) begin
    if (!reset_n) begin
        t_sec_r <= 7'h00;
        t_min_r <= 7'h00;
        t_hr_r <= 6'h00;
        t_cen_r <= 1'b0;
        t_cflag_r <= 1'b0;
        t_dow_r <= `DOW_FIRST;
        t_date_r <= `DATE_FIRST;
        t_mon_r <= `MON_FIRST;
        t_yr_r <= 8'h00;
    end else begin
        if (sec_tick) begin
            t_sec_r <= s_sec;
            t_min_r <= s_min;
            t_hr_r <= s_hr;
            t_cflag_r <= s_cflag;
            t_dow_r <= s_dow;
            t_date_r <= s_date;
            t_mon_r <= s_mon;
            t_yr_r <= s_yr;
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_SECONDS)) begin
            t_sec_r <= wr_data[6:0];
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_MINUTES)) begin
            t_min_r <= wr_data[6:0];
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_HOURS)) begin
            t_hr_r <= wr_data[5:0];
            t_cen_r <= wr_data[`HR_CEN_BIT];
            t_cflag_r <= wr_data[`HR_CFLAG_BIT];
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_WEEKDAY)) begin
            t_dow_r <= wr_data[2:0];
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_DATE)) begin
            t_date_r <= wr_data[5:0];
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_MONTH)) begin
            t_mon_r <= wr_data[4:0];
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_YEAR)) begin
            t_yr_r <= wr_data;
        end
    end
end

////////////////////////////////////////////////////////////////////
// Halt and control bytes

always @(posedge sys_clk) begin
    if (!reset_n) begin
        halt_r <= 1'b0;
        ctrl_r <= `CTL_RESET;
    end else begin
        if (wr_hit(wr_stb, reg_ptr_r, `REG_SECONDS)) begin
            halt_r <= wr_data[`SEC_HALT_BIT];
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_CONTROL)) begin
            ctrl_r <= wr_data;
        end
    end
end

////////////////////////////////////////////////////////////////////
// Read freeze: set by a time read, ends at bus idle or after the
// hold time, so a stuck bus cannot stall the visible copy forever

assign hold_start = rd_stb && is_clock_addr(reg_ptr_r);
assign copy_ok = !hold_r && !hold_start;

always @(posedge sys_clk) begin
    if (!reset_n) begin
        hold_r <= 1'b0;
        hold_cnt_r <= {HOLD_W{1'b0}};
    end else if (hold_r) begin
        if (!bus_active || (hold_cnt_r == HOLD_LAST)) begin
            hold_r <= 1'b0;
        end else begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
        end
    end else if (hold_start) begin
        hold_r <= 1'b1;
        hold_cnt_r <= {HOLD_W{1'b0}};
    end
end

// Visible copy follows true time unless frozen; writes land at once
always @(posedge sys_clk) begin
    if (!reset_n) begin
        v_sec_r <= 7'h00;
        v_min_r <= 7'h00;
        v_hr_r <= 6'h00;
        v_cen_r <= 1'b0;
        v_cflag_r <= 1'b0;
        v_dow_r <= `DOW_FIRST;
        v_date_r <= `DATE_FIRST;
        v_mon_r <= `MON_FIRST;
        v_yr_r <= 8'h00;
    end else begin
        if (copy_ok) begin
            v_sec_r <= t_sec_r;
            v_min_r <= t_min_r;
            v_hr_r <= t_hr_r;
            v_cen_r <= t_cen_r;
            v_cflag_r <= t_cflag_r;
            v_dow_r <= t_dow_r;
            v_date_r <= t_date_r;
            v_mon_r <= t_mon_r;
            v_yr_r <= t_yr_r;
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_SECONDS)) begin
            v_sec_r <= wr_data[6:0];
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_MINUTES)) begin
            v_min_r <= wr_data[6:0];
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_HOURS)) begin
            v_hr_r <= wr_data[5:0];
            v_cen_r <= wr_data[`HR_CEN_BIT];
            v_cflag_r <= wr_data[`HR_CFLAG_BIT];
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_WEEKDAY)) begin
            v_dow_r <= wr_data[2:0];
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_DATE)) begin
            v_date_r <= wr_data[5:0];
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_MONTH)) begin
            v_mon_r <= wr_data[4:0];
        end
        if (wr_hit(wr_stb, reg_ptr_r, `REG_YEAR)) begin
            v_yr_r <= wr_data;
        end
    end
end

////////////////////////////////////////////////////////////////////
// Read data: latched on the read strobe; unused bits read zero

always @(posedge sys_clk) begin
    if (!reset_n) begin
        rd_data_r <= 8'h00;
    end else if (rd_stb) begin
        case (reg_ptr_r)
            `REG_SECONDS: rd_data_r <= {halt_r, v_sec_r};
            `REG_MINUTES: rd_data_r <= {1'b0, v_min_r};
            `REG_HOURS: rd_data_r <= {v_cen_r, v_cflag_r, v_hr_r};
            `REG_WEEKDAY: rd_data_r <= {5'h00, v_dow_r};
            `REG_DATE: rd_data_r <= {2'b00, v_date_r};
            `REG_MONTH: rd_data_r <= {3'b000, v_mon_r};
            `REG_YEAR: rd_data_r <= v_yr_r;
            `REG_CONTROL: rd_data_r <= ctrl_r;
            default: rd_data_r <= 8'h00;
        endcase
    end
end

////////////////////////////////////////////////////////////////////
// Open-drain pin: only ever pulls low, released otherwise

assign oe_nxt = ctrl_r[`CTL_FT_BIT] ? !test_wave :
                !ctrl_r[`CTL_OUT_BIT];

always @(posedge sys_clk) begin
    if (!reset_n) begin
        test_or_level_pin_out_r <= 1'b0;
        test_or_level_pin_oe_r <= 1'b0;
    end else begin
        test_or_level_pin_out_r <= 1'b0;
        test_or_level_pin_oe_r <= oe_nxt;
    end
end

endmodule // bcd_calendar_clock_core
`default_nettype wire

// file: dv/bcd_calendar_clock_core_asserts.sv
/*
 * Checker for the calendar clock core: pointer, read port and pin.
 * Assumes it is bound to bcd_calendar_clock_core and sees its ports.
 */
`timescale 1ns/100ps
`default_nettype none

module clock_core_checker (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ptr_load,
    input wire logic [2:0] ptr_value,
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    input wire logic rd_stb,
    input wire logic ack_stb,
    input wire logic [7:0] rd_data_r,
    input wire logic [2:0] reg_ptr_r,
    input wire logic test_or_level_pin_out_r,
    input wire logic test_or_level_pin_oe_r
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////
    // Pin and reset state
    pin_data_low_a: assert property (!test_or_level_pin_out_r)
        else $error("pin data driven high");
    reset_state_a: assert property ($rose(reset_n) |->
        rd_data_r == 8'h00 && reg_ptr_r == 3'h0 && !test_or_level_pin_oe_r)
        else $error("state after reset wrong");
    // Level path checked only when no second write lands meanwhile
    level_follow_a: assert property (
        wr_stb && reg_ptr_r == 3'h7 && !wr_data[6] ##1 !wr_stb
        |=> test_or_level_pin_oe_r == !$past(wr_data[7], 2))
        else $error("pin does not follow level bit");

    ////////////////////////////////////////////////////////////////////
    // Pointer moves only on load or acknowledge
    ptr_load_a: assert property (ptr_load |=> reg_ptr_r == $past(ptr_value))
        else $error("pointer load missed");
    ptr_ack_a: assert property (ack_stb && !ptr_load |=>
        reg_ptr_r == $past(reg_ptr_r) + 3'h1)
        else $error("pointer did not advance");
    ptr_hold_a: assert property (!ack_stb && !ptr_load |=> $stable(reg_ptr_r))
        else $error("pointer moved without cause");

    ////////////////////////////////////////////////////////////////////
    // Read data
    rd_hold_a: assert property (!rd_stb |=> $stable(rd_data_r))
        else $error("read byte changed without read");
    weekday_bits_a: assert property (rd_stb && reg_ptr_r == 3'h3 |=>
        rd_data_r[7:3] == 5'h00)
        else $error("weekday upper bits not zero");
    minute_bit_a: assert property (rd_stb && reg_ptr_r == 3'h1 |=>
        !rd_data_r[7])
        else $error("minutes bit 7 not zero");

    burst_wrap_c: cover property (ack_stb && reg_ptr_r == 3'h7);
    ctrl_write_c: cover property (wr_stb && reg_ptr_r == 3'h7 && !wr_data[6]);
    weekday_read_c: cover property (rd_stb && reg_ptr_r == 3'h3);
endmodule // clock_core_checker

bind bcd_calendar_clock_core clock_core_checker chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .ptr_load(ptr_load),
    .ptr_value(ptr_value), .wr_stb(wr_stb), .wr_data(wr_data),
    .rd_stb(rd_stb), .ack_stb(ack_stb), .rd_data_r(rd_data_r),
    .reg_ptr_r(reg_ptr_r),
    .test_or_level_pin_out_r(test_or_level_pin_out_r),
    .test_or_level_pin_oe_r(test_or_level_pin_oe_r)
);

`default_nettype wire

// file: dv/serial_host_model.sv
/*
 * Serial bus host seen through the slave's strobes: pointer loads,
 * byte writes, reads with or without acknowledge.
 * Assumes the core answers a read one cycle after its strobe.
 */
`timescale 1ns/100ps
`default_nettype none

module serial_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] rd_data_r,
    output logic bus_active,
    output logic ptr_load,
    output logic [2:0] ptr_value,
    output logic wr_stb,
    output logic [7:0] wr_data,
    output logic rd_stb,
    output logic ack_stb
);
    // Idle bus at time zero
    initial begin
        bus_active = 1'b0;
        ptr_load = 1'b0;
        ptr_value = 3'h0;
        wr_stb = 1'b0;
        wr_data = 8'h00;
        rd_stb = 1'b0;
        ack_stb = 1'b0;
    end

    // Address byte; stale value inverted so nothing leans on it
    task automatic load(input logic [2:0] p);
        @(posedge sys_clk);
        bus_active <= 1'b1;
        ptr_load <= 1'b1;
        ptr_value <= p;
        @(posedge sys_clk);
        ptr_load <= 1'b0;
        ptr_value <= ~p;
    endtask

    task automatic put(input logic [2:0] p, input logic [7:0] d);
        load(p);
        wr_stb <= 1'b1;
        wr_data <= d;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        wr_data <= ~d;
        bus_active <= 1'b0;
    endtask

    // One byte out of the slave; acknowledge moves the pointer on.
    // Byte taken at the acknowledge edge, where it already stands;
    // one idle edge follows so the moved pointer has settled.
    task automatic rd_next(output logic [7:0] d, input logic ack);
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        ack_stb <= ack;
        @(posedge sys_clk);
        d = rd_data_r;
        ack_stb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic get(input logic [2:0] p, output logic [7:0] d);
        load(p);
        rd_next(d, 1'b0);
        bus_active <= 1'b0;
    endtask

    // Oscillator kick-start after power-up: halt then release
    task automatic kick();
        put(3'h0, 8'h80);
        put(3'h0, 8'h00);
    endtask
endmodule // serial_host_model

`default_nettype wire

// file: dv/test_bcd_calendar_clock_core.sv
/*
 * Self-checking bench for the calendar clock core: register map,
 * bursts, pointer, level and test-wave pin, halt.
 * Assumes the crystal is sped up to 8 sys_clk cycles per period;
 * a full second never elapses, so only the divider's wave is timed.
 */
`timescale 1ns/100ps
`default_nettype none

module test_bcd_calendar_clock_core;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic osc_clk_pin = 1'b0;
    logic bus_active, ptr_load, wr_stb, rd_stb, ack_stb;
    logic [2:0] ptr_value, reg_ptr_r;
    logic [7:0] wr_data, rd_data_r, got;
    logic pin_out, pin_oe;
    wire pin_level = pin_oe ? pin_out : 1'b1;
    int error_cnt = 0;
    int tests_run = 0;
    int n;
    localparam logic [63:0] RST_VALS = 64'h80_00_01_01_01_00_00_00;
    localparam logic [63:0] WR_VALS = 64'h00_99_f2_f1_fd_e3_d9_59;
    localparam logic [63:0] RD_VALS = 64'h80_99_12_31_05_e3_59_59;
    localparam logic [23:0] FT_CTRL = 24'h7f_5f_40;

    bcd_calendar_clock_core #(.HOLD_CYCLES(64), .HOLD_W(23)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .osc_clk_pin(osc_clk_pin),
        .bus_active(bus_active), .ptr_load(ptr_load),
        .ptr_value(ptr_value), .wr_stb(wr_stb), .wr_data(wr_data),
        .rd_stb(rd_stb), .ack_stb(ack_stb), .rd_data_r(rd_data_r),
        .reg_ptr_r(reg_ptr_r), .test_or_level_pin_out_r(pin_out),
        .test_or_level_pin_oe_r(pin_oe)
    );

    serial_host_model host (
        .sys_clk(sys_clk), .rd_data_r(rd_data_r), .bus_active(bus_active),
        .ptr_load(ptr_load), .ptr_value(ptr_value), .wr_stb(wr_stb),
        .wr_data(wr_data), .rd_stb(rd_stb), .ack_stb(ack_stb)
    );

    ////////////////////////////////////////////////////////////////////
    // System clock, and a fast stand-in crystal to keep the run short
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        forever begin
            repeat (4) @(posedge sys_clk);
            osc_clk_pin <= ~osc_clk_pin;
        end
    end

    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t byte %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_ok(input logic ok);
        tests_run++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t pin check failed", $time);
        end
    endtask

    // Edges of the pin level over a fixed window
    task automatic toggles(input int cycles, output int cnt);
        logic last;
        cnt = 0;
        last = pin_level;
        repeat (cycles) begin
            @(posedge sys_clk);
            if (pin_level !== last) cnt++;
            last = pin_level;
        end
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (60000) @(posedge sys_clk);
        error_cnt++;
        $display("BAD %0t run timed out", $time);
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1 cmp_ok(pin_level === 1'b1);
        for (int i = 0; i < 8; i++) begin
            host.get(3'(i), got);
            cmp8(got, RST_VALS[8*i +: 8]);
        end
        host.kick();
        // Every time field, with don't-care bits set to catch leaks
        for (int i = 0; i < 7; i++) begin
            host.put(3'(i), WR_VALS[8*i +: 8]);
            host.get(3'(i), got);
            cmp8(got, RD_VALS[8*i +: 8]);
        end
        // Burst across the control byte and the wrap to zero
        host.load(3'h5);
        for (int i = 0; i < 4; i++) begin
            host.rd_next(got, 1'b1);
            cmp8(got, RD_VALS[8*((5 + i) % 8) +: 8]);
            cmp8({5'h00, reg_ptr_r}, 8'((6 + i) % 8));
        end
        host.rd_next(got, 1'b0);
        cmp8({5'h00, reg_ptr_r}, 8'h01);
        host.put(3'h7, 8'h00);
        repeat (3) @(posedge sys_clk);
        cmp_ok(pin_level === 1'b0);
        host.put(3'h7, 8'h80);
        repeat (3) @(posedge sys_clk);
        cmp_ok(pin_level === 1'b1);
        // Test wave: 32 rising crystal edges per half period with trim off and at full trim of either sign
        for (int i = 0; i < 3; i++) begin
            host.put(3'h7, FT_CTRL[8*i +: 8]);
            host.get(3'h7, got);
            cmp8(got, FT_CTRL[8*i +: 8]);
            toggles(2560, n);
            cmp_ok(n >= 9 && n <= 11);
        end
        host.put(3'h0, 8'h80);
        repeat (8) @(posedge sys_clk);
        toggles(1000, n);
        cmp_ok(n == 0);
        host.get(3'h0, got);
        cmp8(got, 8'h80);
        host.put(3'h0, 8'h00);
        toggles(600, n);
        cmp_ok(n >= 1);
        finish_test();
    end
endmodule // test_bcd_calendar_clock_core

`default_nettype wire
